// ### rtl/hfb_bridge.sv
`default_nettype none
module hfb_bridge
  import hfb_pkg::*;
(
  input  wire logic            ref_clk,
  input  wire logic            reset,
  input  wire logic            ce,
  input  wire logic            lclk,
  input  wire logic            lframe_n,
  input  wire logic [3:0]      lad_in,
  output logic      [3:0]      lad_out,
  output logic                 lad_oe,
  input  wire logic            host_write_allow,
  input  wire logic            lpc_memory_decode_enable,
  input  wire logic            fw_hub_decode_enable,
  input  wire logic            extended_bios_select,
  input  wire logic            user_window_enable,
  input  wire logic [15:0]     user_window_base,
  input  wire logic [2:0]      flash_size_select,
  input  wire logic [63:0]     read_protect,
  input  wire logic [63:0]     write_protect,
  input  wire logic            ec_fetch_busy,
  output logic                 ec_fetch_stall,
  output logic                 mbus_req,
  output logic [FA_W-1:0]      mbus_addr,
  output logic                 mbus_we,
  output logic [7:0]           mbus_wdata,
  input  wire logic [7:0]      mbus_rdata,
  input  wire logic            mbus_done
);
  logic [SYNC_W-2:0] pins_s;
  logic              rise;
  logic [3:0]        lad_s;
  logic              lframe_s_n;

  hfb_pin_sync u_sync (
    .ref_clk   (ref_clk),
    .reset     (reset),
    .ce        (ce),
    .pins_in   ({lclk, lframe_n, lad_in}),
    .pins_sync (pins_s),
    .clk_rise  (rise)
  );

  assign lad_s      = pins_s[3:0];
  assign lframe_s_n = pins_s[4];

  hfb_state_e  st_q;
  hfb_state_e  st_d;
  logic [3:0]  cnt_q;
  logic [3:0]  cnt_d;
  hfb_cyc_s    cyc_q;
  hfb_cyc_s    cyc_d;
  logic [7:0]  rdat_q;
  logic [7:0]  rdat_d;
  logic [3:0]  lad_out_q;
  logic [3:0]  lad_out_d;
  logic        lad_oe_q;
  logic        lad_oe_d;
  logic [31:0] ind_addr_q;
  logic [31:0] ind_addr_d;
  logic        issue;
  logic        consume;

  hfb_mreq_s   mreq_q;
  hfb_mreq_s   mreq_d;
  logic        req_q;
  logic        req_d;
  logic        grant_q;
  logic        grant_d;
  logic        done_q;
  logic        done_d;
  logic [7:0]  mrdata_q;
  logic [7:0]  mrdata_d;

  logic [31:0]     tgt;
  logic [4:0]      shamt;
  logic [FA_W-1:0] mask;
  hfb_dec_s        dec;
  logic [5:0]      blk;
  logic            permit;
  logic            io_hit;
  logic [2:0]      reg_sel;
  logic            claim;
  logic            need_mbus;
  logic [7:0]      local_rd;
  logic [3:0]      last_nib;
  logic [31:0]     nxt_addr;

  // Window decode; indirect cycles run through the same path
  always_comb begin
    tgt   = cyc_q.io ? ind_addr_q : cyc_q.addr;
    shamt = FSIZE_MIN_LOG + {2'b00, flash_size_select};
    mask  = ~(FA_ONES << shamt);
    dec   = '0;
    if (tgt[31:16] == LEG_SEG) begin
      dec.hit = 1'b1;
      dec.off = {5'h1F, tgt[16:0]} & mask;
    end else if (extended_bios_select && (tgt[31:16] == EXT_SEG)) begin
      dec.hit = 1'b1;
      dec.off = {5'h1F, tgt[16:0]} & mask;
    end else if ((tgt[31:22] == TOP_HI) && ((tgt[FA_W-1:0] | mask) == FA_ONES)) begin
      dec.hit = 1'b1;
      dec.off = tgt[FA_W-1:0] & mask;
    end else if (user_window_enable && (tgt[31:16] == user_window_base)) begin
      dec.hit = 1'b1;
      dec.off = {6'h00, tgt[15:0]};
    end
    blk = dec.off[FA_W-1:16];
    // Write permission also needs the firmware grant
    permit = cyc_q.we ? (host_write_allow && !write_protect[blk])
                      : !read_protect[blk];
    reg_sel = cyc_q.addr[2:0];
    io_hit  = (cyc_q.addr[15:3] == IND_IO_BASE[15:3]) && (reg_sel <= IND_OFF_DATA);
    if (cyc_q.bad) begin
      claim = 1'b0;
    end else if (cyc_q.io) begin
      claim = lpc_memory_decode_enable && io_hit;
    end else if (cyc_q.fwh) begin
      claim = fw_hub_decode_enable && dec.hit;
    end else begin
      claim = lpc_memory_decode_enable && dec.hit;
    end
    need_mbus = claim && dec.hit && permit && (!cyc_q.io || (reg_sel == IND_OFF_DATA));
    if (cyc_q.io && (reg_sel != IND_OFF_DATA)) begin
      local_rd = ind_addr_q[{reg_sel[1:0], 3'b000} +: 8];
    end else begin
      local_rd = FORBID_RD_DATA;
    end
    if (cyc_q.io) begin
      last_nib = IO_LAST;
    end else if (cyc_q.fwh) begin
      last_nib = FWH_LAST;
    end else begin
      last_nib = MEM_LAST;
    end
  end

  // Link sequencer, advanced on each sampled rising edge of the LPC clock
  always_comb begin
    st_d       = st_q;
    cnt_d      = cnt_q;
    cyc_d      = cyc_q;
    rdat_d     = rdat_q;
    lad_out_d  = lad_out_q;
    lad_oe_d   = lad_oe_q;
    ind_addr_d = ind_addr_q;
    issue      = 1'b0;
    consume    = 1'b0;
    nxt_addr   = {cyc_q.addr[27:0], lad_s};
    if (rise) begin
      if (!lframe_s_n) begin
        // A frame start aborts the link cycle in progress, but not a flash request already issued
        lad_oe_d  = 1'b0;
        cnt_d     = 4'h0;
        cyc_d     = '0;
        cyc_d.fwh = (lad_s == START_FWH_RD) || (lad_s == START_FWH_WR);
        cyc_d.we  = (lad_s == START_FWH_WR);
        if (lad_s == START_LPC) begin
          st_d = ST_CYC;
        end else if (cyc_d.fwh) begin
          st_d = ST_FWID;
        end else begin
          st_d = ST_IDLE;
        end
      end else begin
        case (st_q)
          ST_CYC: begin
            cyc_d.io = (lad_s[3:2] == CT_IO);
            cyc_d.we = lad_s[1];
            st_d = ((lad_s[3:2] == CT_IO) || (lad_s[3:2] == CT_MEM)) ? ST_ADDR : ST_IDLE;
          end
          ST_FWID: begin
            cyc_d.bad  = (lad_s != FWH_IDSEL);
            cyc_d.addr = FWH_ADDR_TOP;
            st_d = ST_ADDR;
          end
          ST_ADDR: begin
            cyc_d.addr = cyc_q.fwh ? {FWH_ADDR_TOP[31:28], nxt_addr[27:0]} : nxt_addr;
            cnt_d = cnt_q + 4'h1;
            if (cnt_q == last_nib) begin
              cnt_d = 4'h0;
              if (cyc_q.fwh) begin
                st_d = ST_MSIZE;
              end else begin
                st_d = cyc_q.we ? ST_WDAT : ST_HTAR;
              end
            end
          end
          ST_MSIZE: begin
            // Only single-byte transfers are served
            cyc_d.bad = cyc_q.bad || (lad_s != MSIZE_BYTE);
            st_d = cyc_q.we ? ST_WDAT : ST_HTAR;
          end
          ST_WDAT: begin
            cyc_d.data = {lad_s, cyc_q.data[7:4]};
            cnt_d = 4'h1;
            if (cnt_q == 4'h1) begin
              cnt_d = 4'h0;
              st_d = ST_HTAR;
            end
          end
          ST_HTAR: begin
            cnt_d = 4'h1;
            if (cnt_q == 4'h1) begin
              cnt_d = 4'h0;
              if (!claim) begin
                st_d = ST_IDLE;
              end else if (need_mbus) begin
                issue     = 1'b1;
                lad_oe_d  = 1'b1;
                lad_out_d = SYNC_LWAIT;
                st_d = ST_SYNC;
              end else begin
                // Local register access, or a protected one answered at once
                lad_oe_d  = 1'b1;
                lad_out_d = SYNC_READY;
                rdat_d    = local_rd;
                st_d = cyc_q.we ? ST_TTAR : ST_RDAT;
                if (cyc_q.io && cyc_q.we && (reg_sel != IND_OFF_DATA)) begin
                  ind_addr_d[{reg_sel[1:0], 3'b000} +: 8] = cyc_q.data;
                end
              end
            end
          end
          ST_SYNC: begin
            if (done_q) begin
              consume   = 1'b1;
              lad_out_d = SYNC_READY;
              rdat_d    = mrdata_q;
              st_d = cyc_q.we ? ST_TTAR : ST_RDAT;
            end else begin
              lad_out_d = SYNC_LWAIT;
            end
          end
          ST_RDAT: begin
            cnt_d     = 4'h1;
            lad_out_d = rdat_q[3:0];
            if (cnt_q == 4'h1) begin
              cnt_d     = 4'h0;
              lad_out_d = rdat_q[7:4];
              st_d = ST_TTAR;
            end
          end
          ST_TTAR: begin
            cnt_d     = 4'h1;
            lad_out_d = TAR_NIB;
            if (cnt_q == 4'h1) begin
              cnt_d    = 4'h0;
              lad_oe_d = 1'b0;
              st_d = ST_IDLE;
            end
          end
          ST_IDLE: begin
            st_d = ST_IDLE;
          end
          default: begin
            st_d     = ST_IDLE;
            lad_oe_d = 1'b0;
          end
        endcase
      end
    end
    if (!ce) begin
      issue   = 1'b0;
      consume = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      st_q       <= ST_IDLE;
      cnt_q      <= 4'h0;
      cyc_q      <= '0;
      rdat_q     <= BYTE_RST;
      lad_out_q  <= TAR_NIB;
      lad_oe_q   <= 1'b0;
      ind_addr_q <= IND_ADDR_RST;
    end else if (ce) begin
      st_q       <= st_d;
      cnt_q      <= cnt_d;
      cyc_q      <= cyc_d;
      rdat_q     <= rdat_d;
      lad_out_q  <= lad_out_d;
      lad_oe_q   <= lad_oe_d;
      ind_addr_q <= ind_addr_d;
    end
  end

  // Flash-side request and arbitration; the controller owns the bus at rest
  always_comb begin
    mreq_d   = mreq_q;
    req_d    = req_q;
    grant_d  = grant_q;
    done_d   = done_q;
    mrdata_d = mrdata_q;
    if (consume) begin
      done_d = 1'b0;
    end
    if (issue) begin
      req_d        = 1'b1;
      done_d       = 1'b0;
      mreq_d.addr  = dec.off;
      mreq_d.wdata = cyc_q.data;
      mreq_d.we    = cyc_q.we;
    end
    // A fetch already on the bus is let finish before the grant moves
    if (req_q && !grant_q && !ec_fetch_busy) begin
      grant_d = 1'b1;
    end
    if (grant_q && mbus_done) begin
      grant_d  = 1'b0;
      req_d    = 1'b0;
      done_d   = 1'b1;
      mrdata_d = mbus_rdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      mreq_q   <= '0;
      req_q    <= 1'b0;
      grant_q  <= 1'b0;
      done_q   <= 1'b0;
      mrdata_q <= BYTE_RST;
    end else if (ce) begin
      mreq_q   <= mreq_d;
      req_q    <= req_d;
      grant_q  <= grant_d;
      done_q   <= done_d;
      mrdata_q <= mrdata_d;
    end
  end

  assign lad_out        = lad_out_q;
  assign lad_oe         = lad_oe_q;
  assign mbus_req       = grant_q;
  assign ec_fetch_stall = grant_q;
  assign mbus_addr      = mreq_q.addr;
  assign mbus_we        = mreq_q.we;
  assign mbus_wdata     = mreq_q.wdata;
endmodule
`default_nettype wire

// ### pkg/hfb_pkg.sv
`default_nettype none
package hfb_pkg;
  localparam int unsigned FA_W  = 22;
  localparam int unsigned SYNC_W = 6;

  // Synchroniser bit order {lclk, lframe_n, lad[3:0]}
  // Clock bit resets high, the level a host parks it at, so no false edge follows reset
  localparam logic [SYNC_W-1:0] SYNC_RST = 6'h3F;

  localparam logic [3:0] START_LPC    = 4'h0;
  localparam logic [3:0] START_FWH_RD = 4'hD;
  localparam logic [3:0] START_FWH_WR = 4'hE;
  localparam logic [1:0] CT_IO        = 2'h0;
  localparam logic [1:0] CT_MEM       = 2'h1;
  localparam logic [3:0] SYNC_READY   = 4'h0;
  localparam logic [3:0] SYNC_LWAIT   = 4'h6;
  localparam logic [3:0] TAR_NIB      = 4'hF;
  localparam logic [3:0] FWH_IDSEL    = 4'h0;
  localparam logic [3:0] MSIZE_BYTE   = 4'h0;

  // Index of the last address nibble per cycle kind
  localparam logic [3:0] IO_LAST  = 4'h3;
  localparam logic [3:0] MEM_LAST = 4'h7;
  localparam logic [3:0] FWH_LAST = 4'h6;

  localparam logic [15:0] IND_IO_BASE   = 16'h0680;
  localparam logic [2:0]  IND_OFF_ADDR0 = 3'h0;
  localparam logic [2:0]  IND_OFF_DATA  = 3'h4;

  localparam logic [31:0]     FWH_ADDR_TOP = 32'hF000_0000;
  localparam logic [9:0]      TOP_HI       = 10'h3FF;
  localparam logic [15:0]     LEG_SEG      = 16'h000F;
  localparam logic [15:0]     EXT_SEG      = 16'h000E;
  localparam logic [FA_W-1:0] FA_ONES      = 22'h3F_FFFF;
  localparam logic [4:0]      FSIZE_MIN_LOG = 5'h11;

  localparam logic [7:0]  FORBID_RD_DATA = 8'hFF;
  localparam logic [31:0] IND_ADDR_RST   = 32'h0000_0000;
  localparam logic [7:0]  BYTE_RST       = 8'h00;

  typedef enum logic [9:0] {
    ST_IDLE  = 10'h001,
    ST_CYC   = 10'h002,
    ST_FWID  = 10'h004,
    ST_ADDR  = 10'h008,
    ST_MSIZE = 10'h010,
    ST_WDAT  = 10'h020,
    ST_HTAR  = 10'h040,
    ST_SYNC  = 10'h080,
    ST_RDAT  = 10'h100,
    ST_TTAR  = 10'h200
  } hfb_state_e;

  typedef struct packed {
    logic [31:0] addr;
    logic [7:0]  data;
    logic        we;
    logic        io;
    logic        fwh;
    logic        bad;
  } hfb_cyc_s;

  typedef struct packed {
    logic            hit;
    logic [FA_W-1:0] off;
  } hfb_dec_s;

  typedef struct packed {
    logic [FA_W-1:0] addr;
    logic [7:0]      wdata;
    logic            we;
  } hfb_mreq_s;
endpackage
`default_nettype wire

// ### rtl/hfb_pin_sync.sv
`default_nettype none
module hfb_pin_sync
  import hfb_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              reset,
  input  wire logic              ce,
  input  wire logic [SYNC_W-1:0] pins_in,
  output logic      [SYNC_W-2:0] pins_sync,
  output logic                   clk_rise
);
  logic [SYNC_W-1:0] sync_bits;
  logic [SYNC_W-2:0] dly1_q;
  logic [SYNC_W-2:0] dly1_d;
  logic [SYNC_W-2:0] dly2_q;
  logic [SYNC_W-2:0] dly2_d;
  logic              prev_q;
  logic              prev_d;
  logic              rise_q;
  logic              rise_d;

  genvar i;
  generate
    for (i = 0; i < SYNC_W; i++) begin : g_bit
      logic meta_q;
      logic meta_d;
      logic sync_q;
      logic sync_d;
      always_comb begin
        meta_d = ce ? pins_in[i] : meta_q;
        sync_d = ce ? meta_q : sync_q;
      end
      always_ff @(posedge ref_clk) begin
        if (reset) begin
          meta_q <= SYNC_RST[i];
          sync_q <= SYNC_RST[i];
        end else begin
          meta_q <= meta_d;
          sync_q <= sync_d;
        end
      end
      assign sync_bits[i] = sync_q;
    end
  endgenerate

  // Data is taken from the sample before the edge was seen, since the host
  // may already change its pins right after its rising edge.
  always_comb begin
    dly1_d = ce ? sync_bits[SYNC_W-2:0] : dly1_q;
    dly2_d = ce ? dly1_q : dly2_q;
    prev_d = ce ? sync_bits[SYNC_W-1] : prev_q;
    rise_d = ce ? (sync_bits[SYNC_W-1] & ~prev_q) : 1'b0;
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      dly1_q <= SYNC_RST[SYNC_W-2:0];
      dly2_q <= SYNC_RST[SYNC_W-2:0];
      prev_q <= SYNC_RST[SYNC_W-1];
      rise_q <= 1'b0;
    end else begin
      dly1_q <= dly1_d;
      dly2_q <= dly2_d;
      prev_q <= prev_d;
      rise_q <= rise_d;
    end
  end

  assign pins_sync = dly2_q;
  assign clk_rise  = rise_q;
endmodule
`default_nettype wire

// ### verif/hfb_bridge_checker.sv
`default_nettype none
module hfb_bridge_checker
  import hfb_pkg::*;
(
  input wire logic            ref_clk,
  input wire logic            reset,
  input wire logic            ec_fetch_busy,
  input wire logic            ec_fetch_stall,
  input wire logic            mbus_req,
  input wire logic [FA_W-1:0] mbus_addr,
  input wire logic            mbus_we,
  input wire logic [7:0]      mbus_wdata,
  input wire logic            mbus_done,
  input wire logic            host_write_allow,
  input wire logic            lpc_memory_decode_enable,
  input wire logic            fw_hub_decode_enable,
  input wire logic [63:0]     read_protect,
  input wire logic [63:0]     write_protect,
  input wire logic [3:0]      lad_out,
  input wire logic            lad_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);

  AST_STALL_IS_GRANT: assert property (ec_fetch_stall == mbus_req)
    else $error("stall differs from grant");
  AST_REQ_HELD: assert property (mbus_req && !mbus_done |=> mbus_req &&
    $stable(mbus_addr) && $stable(mbus_we) && $stable(mbus_wdata))
    else $error("request changed before done");
  AST_REQ_ENDS: assert property (mbus_req && mbus_done |=> !mbus_req)
    else $error("request kept after done");
  AST_GRANT_WAITS: assert property ($rose(mbus_req) |-> !$past(ec_fetch_busy))
    else $error("grant taken during controller fetch");
  AST_WRITE_ALLOW: assert property (mbus_req && mbus_we |-> host_write_allow)
    else $error("host write without allow");
  AST_DECODE_ON: assert property (mbus_req |->
    lpc_memory_decode_enable || fw_hub_decode_enable)
    else $error("request with decoding off");
  AST_RD_PROT: assert property (mbus_req && !mbus_we |->
    !read_protect[mbus_addr[21:16]])
    else $error("read of protected block");
  AST_WR_PROT: assert property (mbus_req && mbus_we |->
    !write_protect[mbus_addr[21:16]])
    else $error("write of protected block");
  AST_LONG_WAIT: assert property ($rose(mbus_req) |-> ##[0:6]
    (lad_oe && lad_out == SYNC_LWAIT))
    else $error("no long wait while flash busy");
endmodule

bind hfb_bridge hfb_bridge_checker u_chk (
  .ref_clk, .reset, .ec_fetch_busy, .ec_fetch_stall, .mbus_req, .mbus_addr, .mbus_we,
  .mbus_wdata, .mbus_done, .host_write_allow, .lpc_memory_decode_enable,
  .fw_hub_decode_enable, .read_protect, .write_protect, .lad_out, .lad_oe
);
`default_nettype wire

// ### verif/hfb_lpc_host.sv
`default_nettype none
module hfb_lpc_host
  import hfb_pkg::*;
(
  output logic            lclk,
  output logic            lframe_n,
  output logic [3:0]      lad_h,
  output logic            lad_h_oe,
  input  wire logic [3:0] lad
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] seen;

  initial begin
    lclk = 1'b0;
    lframe_n = 1'b1;
    lad_h = TAR_NIB;
    lad_h_oe = 1'b0;
  end

  // Clock only ticks during a transfer, so the device cannot lean on a free-running clock
  task automatic tick(input logic [3:0] nib, input logic oe, input logic fr);
    lclk = 1'b0;
    lad_h = nib;
    lad_h_oe = oe;
    lframe_n = fr;
    #80;
    seen = lad;
    lclk = 1'b1;
    #80;
  endtask

  task automatic xfer(input logic [1:0] k, input logic we, input logic [31:0] a,
                      input logic [7:0] wd, output logic cl, output int nw,
                      output logic [7:0] rd);
    int n;
    rd = 8'h00;
    nw = 0;
    #3;
    tick(TAR_NIB, 1'b0, 1'b1);
    tick(TAR_NIB, 1'b0, 1'b1);
    tick(k == 2'h2 ? (we ? START_FWH_WR : START_FWH_RD) : START_LPC, 1'b1, 1'b0);
    tick(k == 2'h2 ? FWH_IDSEL : {1'b0, k == 2'h0, we, 1'b0}, 1'b1, 1'b1);
    n = (k == 2'h0) ? 8 : ((k == 2'h1) ? 4 : 7);
    for (int i = n - 1; i >= 0; i--) tick(a[4*i +: 4], 1'b1, 1'b1);
    if (k == 2'h2) tick(MSIZE_BYTE, 1'b1, 1'b1);
    if (we) begin
      tick(wd[3:0], 1'b1, 1'b1);
      tick(wd[7:4], 1'b1, 1'b1);
    end
    tick(TAR_NIB, 1'b1, 1'b1);
    tick(TAR_NIB, 1'b0, 1'b1);
    // Bounded so a device stuck in long wait still lets the frame end
    do begin
      tick(TAR_NIB, 1'b0, 1'b1);
      nw += int'(seen === SYNC_LWAIT);
    end while (seen === SYNC_LWAIT && nw < 200);
    cl = (seen === SYNC_READY);
    if (cl && !we) begin
      tick(TAR_NIB, 1'b0, 1'b1);
      rd[3:0] = seen;
      tick(TAR_NIB, 1'b0, 1'b1);
      rd[7:4] = seen;
    end
    if (cl) tick(TAR_NIB, 1'b0, 1'b1);
    tick(TAR_NIB, 1'b0, 1'b1);
  endtask
endmodule
`default_nettype wire

// ### verif/hfb_bridge_tb.sv
`default_nettype none
module hfb_bridge_tb
  import hfb_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  typedef struct packed {
    logic [1:0]      k;
    logic            we;
    logic [31:0]     a;
    logic [7:0]      wd;
    logic [4:0]      ctl;
    logic            cl;
    logic            mb;
    logic [FA_W-1:0] off;
    logic [7:0]      rd;
  } hfb_row_s;

  logic            ref_clk = 1'b0;
  logic            reset = 1'b1;
  logic [4:0]      ctl = 5'h1F;
  logic [2:0]      fsz = 3'h5;
  logic            busy = 1'b0;
  logic            mbus_done = 1'b0;
  logic [7:0]      mbus_rdata = 8'h00;
  logic            lclk, lframe_n, lad_h_oe, lad_oe, mbus_req, mbus_we, l_we, stall;
  logic [3:0]      lad_h, lad_out, lad_w;
  logic [FA_W-1:0] mbus_addr, l_off;
  logic [7:0]      mbus_wdata, l_wd;
  int              n_fail = 0;
  int              tests_run = 0;
  int              n_mb = 0;
  int              fcnt = 0;
  // Flash latency, 40 cycles, then 2 for the busy test; the flash timing setup is firmware's business
  int              lat = 40;
  int              m0;

  // Ctl bits: write allow, lpc decode, fwh decode, extended bios, user window
  hfb_row_s rows [24] = '{
    '{0,0,32'h000F_1234,8'h00,5'h1F,1,1,22'h3F_1234,8'h6E},
    '{0,0,32'h000E_1234,8'h00,5'h1F,1,1,22'h3E_1234,8'h6E},
    '{0,0,32'h000E_1234,8'h00,5'h1D,0,0,22'h00_0000,8'h00},
    '{0,0,32'hFFC0_0100,8'h00,5'h1F,1,1,22'h00_0100,8'h5A},
    '{0,0,32'h0010_4321,8'h00,5'h1F,1,1,22'h00_4321,8'h7B},
    '{0,0,32'h0010_4321,8'h00,5'h1E,0,0,22'h00_0000,8'h00},
    '{0,0,32'h0020_0000,8'h00,5'h1F,0,0,22'h00_0000,8'h00},
    '{0,0,32'hFFFD_0000,8'h00,5'h1F,1,0,22'h00_0000,8'hFF},
    '{0,1,32'hFFD0_0200,8'h3C,5'h1F,1,1,22'h10_0200,8'h00},
    '{0,1,32'hFFC0_0200,8'h3C,5'h1F,1,0,22'h00_0000,8'h00},
    '{0,1,32'h000F_0055,8'hA5,5'h0F,1,0,22'h00_0000,8'h00},
    '{0,1,32'h000F_0055,8'hA5,5'h1F,1,1,22'h3F_0055,8'h00},
    '{0,0,32'h000F_1234,8'h00,5'h17,0,0,22'h00_0000,8'h00},
    '{2,0,32'h0FFF_0010,8'h00,5'h1F,1,1,22'h3F_0010,8'h4A},
    '{2,0,32'h0FFF_0010,8'h00,5'h1B,0,0,22'h00_0000,8'h00},
    '{2,1,32'h0FD0_0300,8'h81,5'h1F,1,1,22'h10_0300,8'h00},
    '{1,1,32'h0000_0680,8'hCD,5'h1F,1,0,22'h00_0000,8'h00},
    '{1,1,32'h0000_0681,8'hAB,5'h1F,1,0,22'h00_0000,8'h00},
    '{1,1,32'h0000_0682,8'hFF,5'h1F,1,0,22'h00_0000,8'h00},
    '{1,1,32'h0000_0683,8'hFF,5'h1F,1,0,22'h00_0000,8'h00},
    '{1,0,32'h0000_0681,8'h00,5'h1F,1,0,22'h00_0000,8'hAB},
    '{1,0,32'h0000_0684,8'h00,5'h1F,1,1,22'h3F_ABCD,8'h97},
    '{1,1,32'h0000_0684,8'h77,5'h1F,1,1,22'h3F_ABCD,8'h00},
    '{1,0,32'h0000_0685,8'h00,5'h1F,0,0,22'h00_0000,8'h00}
  };

  // Pull-up: a released bus reads all ones
  assign lad_w = lad_oe ? lad_out : (lad_h_oe ? lad_h : 4'hF);

  hfb_lpc_host u_host (.lclk, .lframe_n, .lad_h, .lad_h_oe, .lad(lad_w));

  hfb_bridge dut (
    .ref_clk, .reset, .ce(1'b1), .lclk, .lframe_n, .lad_in(lad_w), .lad_out, .lad_oe,
    .host_write_allow(ctl[4]), .lpc_memory_decode_enable(ctl[3]),
    .fw_hub_decode_enable(ctl[2]), .extended_bios_select(ctl[1]),
    .user_window_enable(ctl[0]), .user_window_base(16'h0010), .flash_size_select(fsz),
    .read_protect(64'h2000_0000_0000_0000), .write_protect(64'h0000_0000_0000_0001),
    .ec_fetch_busy(busy), .ec_fetch_stall(stall), .mbus_req, .mbus_addr, .mbus_we,
    .mbus_wdata, .mbus_rdata, .mbus_done
  );

  initial begin
    forever #5 ref_clk = ~ref_clk;
  end

  // Flash side: read byte follows the offset, idle data toggles so stale bytes show
  always @(posedge ref_clk) begin
    mbus_done <= 1'b0;
    mbus_rdata <= ~mbus_rdata;
    if (mbus_req && !mbus_done) begin
      fcnt <= fcnt + 1;
      if (fcnt >= lat) begin
        fcnt <= 0;
        mbus_done <= 1'b1;
        mbus_rdata <= mbus_addr[7:0] ^ 8'h5A;
        n_mb <= n_mb + 1;
        l_off <= mbus_addr;
        l_we <= mbus_we;
        l_wd <= mbus_wdata;
      end
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic run(input hfb_row_s r);
    logic       cl;
    logic [7:0] rd;
    int         nw;
    int         b;
    @(posedge ref_clk);
    ctl <= r.ctl;
    @(posedge ref_clk);
    b = n_mb;
    u_host.xfer(r.k, r.we, r.a, r.wd, cl, nw, rd);
    chk(32'(cl), 32'(r.cl));
    chk(32'(n_mb - b), 32'(r.mb));
    chk(32'(nw != 0), 32'(r.mb));
    if (r.mb) chk(32'({l_we, l_off}), 32'({r.we, r.off}));
    if (r.mb && r.we) chk(32'(l_wd), 32'(r.wd));
    if (r.cl && !r.we) chk(32'(rd), 32'(r.rd));
  endtask

  task automatic conclude();
    if (n_fail == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    #900_000;
    n_fail++;
    conclude();
  end

  initial begin
    repeat (8) @(posedge ref_clk);
    reset <= 1'b0;
    repeat (4) @(posedge ref_clk);
    foreach (rows[i]) run(rows[i]);
    // Smallest flash keeps only the top 128K of the top window
    @(posedge ref_clk);
    fsz <= 3'h0;
    run(hfb_row_s'{0,0,32'hFFFF_1234,8'h00,5'h1F,1,1,22'h01_1234,8'h6E});
    run(hfb_row_s'{0,0,32'hFFC0_0000,8'h00,5'h1F,0,0,22'h00_0000,8'h00});
    @(posedge ref_clk);
    fsz <= 3'h5;
    busy <= 1'b1;
    lat = 2;
    m0 = n_mb;
    fork
      begin
        repeat (300) @(posedge ref_clk);
        chk(32'(n_mb - m0), 32'h0000_0000);
        chk(32'({stall, mbus_req}), 32'h0000_0000);
        busy <= 1'b0;
        @(posedge mbus_req);
        #1;
        chk(32'(stall), 32'h0000_0001);
      end
      run(rows[0]);
    join
    @(posedge ref_clk);
    reset <= 1'b1;
    repeat (4) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    #1;
    chk(32'({mbus_req, lad_oe, lad_out}), 32'h0000_000F);
    run(hfb_row_s'{1,0,32'h0000_0683,8'h00,5'h1F,1,0,22'h00_0000,8'h00});
    conclude();
  end
endmodule
`default_nettype wire
